/* rtl/flash_mode_command_control.sv */
`timescale 1ns/1ns
module flash_mode_command_control
  import flash_mode_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Serial flash link
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_i,
  output logic [3:0]       io_o,
  output logic [3:0]       io_oe
);
  import flash_mode_pkg::*;

  typedef struct packed {
    mode_t      m;
    logic [7:0] nv_sr1;
    logic [7:0] nv_sr2;
    logic       armed;
    logic       tog;
    logic       en_s1;
    logic       en_s2;
  } link_t;

  typedef struct packed {
    link_state_t state;
    logic [5:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  out_sh;
    logic        wr_ok;
    logic        nv;
    logic        byte_idx;
  } frame_t;

  typedef struct packed {
    logic       ctrl_en;
    logic       tog_s1;
    logic       tog_s2;
    logic       tog_s3;
    mode_t      snap;
    logic       ap_valid;
    logic       ap_write;
    logic [6:0] ap_idx;
    logic [31:0] rdata;
  } host_t;

  localparam mode_t MODE_RESET = '{
    cont: 1'b0, quad: 1'b0, addr4: 1'b0, vol_en: 1'b0, wel: 1'b0,
    sr2: SR2_NV_RESET, sr1: SR1_NV_RESET};

  localparam link_t LINK_RESET = '{
    m: MODE_RESET, nv_sr1: SR1_NV_RESET, nv_sr2: SR2_NV_RESET,
    armed: 1'b0, tog: 1'b0, en_s1: 1'b0, en_s2: 1'b0};

  localparam frame_t FRAME_RESET = '{
    state: ST_IDLE, cnt: 6'h00, sh: 8'h00, out_sh: 8'h00,
    wr_ok: 1'b0, nv: 1'b0, byte_idx: 1'b0};

  localparam host_t HOST_RESET = '{
    ctrl_en: CTRL_EN_RESET, tog_s1: 1'b0, tog_s2: 1'b0, tog_s3: 1'b0,
    snap: MODE_RESET, ap_valid: 1'b0, ap_write: 1'b0, ap_idx: 7'h00,
    rdata: 32'h0000_0000};

  link_t       ln_q;
  link_t       ln_d;
  frame_t      fr_q;
  frame_t      fr_d;
  host_t       h_q;
  host_t       h_d;
  link_state_t st;
  logic        wide;
  logic [7:0]  sh_in;
  logic [5:0]  cnt_in;
  logic [7:0]  sr1_view;

  // ---------------- Link domain (sclk) ----------------

  // Status 1 as the host sees it: write-enable latch shown in place
  always_comb begin
    sr1_view          = ln_q.m.sr1;
    sr1_view[WEL_BIT] = ln_q.m.wel;
  end

  always_comb begin
    ln_d = ln_q;
    fr_d = fr_q;
    ln_d.en_s1 = h_q.ctrl_en;
    ln_d.en_s2 = ln_q.en_s1;
    // First edge of a frame decides whether an instruction is expected
    if (fr_q.state == ST_IDLE) begin
      st = ln_q.m.cont ? ST_ADDR : ST_CMD;
    end else begin
      st = fr_q.state;
    end
    // Instruction width follows the current mode, address phases are quad
    wide = ln_q.m.quad || (st == ST_ADDR) || (st == ST_MODE) ||
           (st == ST_DUMMY);
    sh_in  = wide ? {fr_q.sh[3:0], io_i} : {fr_q.sh[6:0], io_i[0]};
    cnt_in = fr_q.cnt + (wide ? 6'h04 : 6'h01);
    fr_d.sh    = sh_in;
    fr_d.cnt   = cnt_in;
    fr_d.state = st;
    unique case (st)
      ST_CMD: begin
        if (cnt_in == BITS_BYTE) begin
          fr_d.cnt   = 6'h00;
          fr_d.state = ST_IGNORE;
          ln_d.armed = 1'b0;
          if (ln_q.en_s2) begin
            unique case (sh_in)
              OP_WREN:     ln_d.m.wel = 1'b1;
              OP_WRDI:     ln_d.m.wel = 1'b0;
              OP_VOL_WREN: ln_d.m.vol_en = 1'b1;
              OP_WRSR: begin
                // 50h takes precedence: write only the volatile copy
                fr_d.wr_ok    = ln_q.m.wel || ln_q.m.vol_en;
                fr_d.nv       = ln_q.m.wel && !ln_q.m.vol_en;
                fr_d.byte_idx = 1'b0;
                fr_d.state    = ST_DIN;
                ln_d.m.wel    = 1'b0;
                ln_d.m.vol_en = 1'b0;
              end
              OP_RDSR1: begin
                fr_d.out_sh = sr1_view;
                fr_d.state  = ST_DOUT;
              end
              OP_RDSR2: begin
                fr_d.out_sh = ln_q.m.sr2;
                fr_d.state  = ST_DOUT;
              end
              OP_RST_EN: ln_d.armed = 1'b1;
              OP_RST: begin
                // Only straight after 66h; the stored values survive
                if (ln_q.armed) begin
                  ln_d.m = '{cont: 1'b0, quad: 1'b0, addr4: 1'b0,
                             vol_en: 1'b0, wel: 1'b0,
                             sr2: ln_q.nv_sr2, sr1: ln_q.nv_sr1};
                end
              end
              OP_ADDR4_EN: ln_d.m.addr4 = 1'b1;
              OP_ADDR4_EX: ln_d.m.addr4 = 1'b0;
              OP_QUAD_EN: begin
                if (ln_q.m.sr2[QE_BIT]) begin
                  ln_d.m.quad = 1'b1;
                end
              end
              OP_QUAD_EX: ln_d.m.quad = 1'b0;
              OP_QIO_READ: fr_d.state = ST_ADDR;
              default: ;
            endcase
          end
        end
      end
      ST_ADDR: begin
        if (cnt_in == (ln_q.m.addr4 ? BITS_ADDR4 : BITS_ADDR3)) begin
          fr_d.cnt   = 6'h00;
          fr_d.state = ST_MODE;
        end
      end
      ST_MODE: begin
        if (cnt_in == BITS_BYTE) begin
          fr_d.cnt    = 6'h00;
          fr_d.state  = ST_DUMMY;
          ln_d.m.cont = (sh_in[7:4] == CONT_NIBBLE);
        end
      end
      ST_DUMMY: begin
        // Array data is served elsewhere; this block only tracks mode
        if (cnt_in == BITS_DUMMY) begin
          fr_d.cnt   = 6'h00;
          fr_d.state = ST_IGNORE;
        end
      end
      ST_DIN: begin
        if (cnt_in == BITS_BYTE) begin
          fr_d.cnt      = 6'h00;
          fr_d.byte_idx = 1'b1;
          if (fr_q.byte_idx) begin
            fr_d.state = ST_IGNORE;
          end
          if (fr_q.wr_ok && !fr_q.byte_idx) begin
            // One byte alone never reaches status register 2
            ln_d.m.sr1 = sh_in;
            ln_d.m.sr1[WEL_BIT] = 1'b0;
            if (fr_q.nv) begin
              ln_d.nv_sr1 = ln_d.m.sr1;
            end
          end
          if (fr_q.wr_ok && fr_q.byte_idx) begin
            ln_d.m.sr2 = sh_in;
            if (fr_q.nv) begin
              ln_d.nv_sr2 = sh_in;
            end
          end
        end
      end
      ST_DOUT: begin
        // Register repeats for as long as the host keeps clocking
        fr_d.cnt    = 6'h00;
        fr_d.out_sh = ln_q.m.quad ? {fr_q.out_sh[3:0], fr_q.out_sh[7:4]}
                                  : {fr_q.out_sh[6:0], fr_q.out_sh[7]};
      end
      ST_IDLE, ST_IGNORE: begin
        fr_d.cnt = 6'h00;
      end
    endcase
    // Any change of mode is announced to the bus side by a toggle
    if (ln_d.m != ln_q.m) begin
      ln_d.tog = ~ln_q.tog;
    end
  end

  // Mode state lives across frames, power-up reset only
  always_ff @(posedge sclk or negedge hresetn) begin
    if (!hresetn) begin
      ln_q <= LINK_RESET;
    end else begin
      ln_q <= ln_d;
    end
  end

  // Frame state is cleared by chip select, since sclk stops between frames
  always_ff @(posedge sclk or negedge hresetn or posedge cs_n) begin
    if (!hresetn || cs_n) begin
      fr_q <= FRAME_RESET;
    end else begin
      fr_q <= fr_d;
    end
  end

  // Output changes on the rising edge; hosts sample on the next one
  always_comb begin
    io_oe = 4'h0;
    io_o  = 4'h0;
    if (fr_q.state == ST_DOUT) begin
      if (ln_q.m.quad) begin
        io_oe = 4'hF;
        io_o  = fr_q.out_sh[7:4];
      end else begin
        io_oe = 4'h2;
        io_o  = {2'b00, fr_q.out_sh[7], 1'b0};
      end
    end
  end

  // ---------------- Bus domain (hclk) ----------------

  function automatic logic [31:0] read_word(input logic [6:0] idx,
                                            input host_t    h);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (idx)
      IDX_QE_METHODS:  w = {24'h00_0000, VAL_QE_METHODS};
      IDX_RESERVED:    w = {24'h00_0000, VAL_RESERVED};
      IDX_SR_VOLATILE: w = {24'h00_0000, VAL_SR_VOLATILE};
      IDX_SOFT_RESET:  w = {24'h00_0000, VAL_SOFT_RESET};
      IDX_ADDR4_EXIT:  w = {24'h00_0000, VAL_ADDR4_EXIT};
      IDX_ADDR4_ENTRY: w = {24'h00_0000, VAL_ADDR4_ENTRY};
      IDX_STATUS:      w = {11'h000, h.snap};
      IDX_CTRL:        w = {31'h0000_0000, h.ctrl_en};
      default:         w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  always_comb begin
    h_d = h_q;
    h_d.tog_s1 = ln_q.tog;
    h_d.tog_s2 = h_q.tog_s1;
    h_d.tog_s3 = h_q.tog_s2;
    // Snapshot is stable: a command takes far longer than the crossing
    if (h_q.tog_s2 != h_q.tog_s3) begin
      h_d.snap = ln_q.m;
    end
    // Data phase write; parameter bytes ignore writes
    if (h_q.ap_valid && h_q.ap_write && (h_q.ap_idx == IDX_CTRL)) begin
      h_d.ctrl_en = hwdata[CTRL_EN_BIT];
    end
    h_d.ap_valid = hsel && htrans[1] && hready;
    if (hsel && htrans[1] && hready) begin
      h_d.ap_write = hwrite;
      h_d.ap_idx   = (haddr[31:9] == 23'h00_0000) ? haddr[8:2] : 7'h00;
      h_d.rdata    = hwrite ? 32'h0000_0000 : read_word(haddr[8:2], h_q);
      if (haddr[31:9] != 23'h00_0000) begin
        h_d.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      h_q <= HOST_RESET;
    end else if (ce) begin
      h_q <= h_d;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = h_q.rdata;

endmodule // flash_mode_command_control

/* include/flash_mode_pkg.sv */
package flash_mode_pkg;

  // Parameter byte indices; byte address on the bus is four times the index
  localparam logic [6:0] IDX_QE_METHODS  = 7'h6A;
  localparam logic [6:0] IDX_RESERVED    = 7'h6B;
  localparam logic [6:0] IDX_SR_VOLATILE = 7'h6C;
  localparam logic [6:0] IDX_SOFT_RESET  = 7'h6D;
  localparam logic [6:0] IDX_ADDR4_EXIT  = 7'h6E;
  localparam logic [6:0] IDX_ADDR4_ENTRY = 7'h6F;
  localparam logic [6:0] IDX_STATUS      = 7'h70;
  localparam logic [6:0] IDX_CTRL        = 7'h71;

  // Parameter byte contents
  localparam logic [7:0] VAL_QE_METHODS  = 8'h44;
  localparam logic [7:0] VAL_RESERVED    = 8'hFF;
  localparam logic [7:0] VAL_SR_VOLATILE = 8'h88;
  localparam logic [7:0] VAL_SOFT_RESET  = 8'h50;
  localparam logic [7:0] VAL_ADDR4_EXIT  = 8'h00;
  localparam logic [7:0] VAL_ADDR4_ENTRY = 8'h01;

  // Control register
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam logic        CTRL_EN_RESET = 1'b1;

  // Instruction codes
  localparam logic [7:0] OP_WREN     = 8'h06;
  localparam logic [7:0] OP_WRDI     = 8'h04;
  localparam logic [7:0] OP_VOL_WREN = 8'h50;
  localparam logic [7:0] OP_WRSR     = 8'h01;
  localparam logic [7:0] OP_RDSR1    = 8'h05;
  localparam logic [7:0] OP_RDSR2    = 8'h35;
  localparam logic [7:0] OP_RST_EN   = 8'h66;
  localparam logic [7:0] OP_RST      = 8'h99;
  localparam logic [7:0] OP_ADDR4_EN = 8'hB7;
  localparam logic [7:0] OP_ADDR4_EX = 8'hE9;
  localparam logic [7:0] OP_QUAD_EN  = 8'h38;
  localparam logic [7:0] OP_QUAD_EX  = 8'hFF;
  localparam logic [7:0] OP_QIO_READ = 8'hEB;

  // Status fields and reset values
  localparam int unsigned QE_BIT       = 1;
  localparam int unsigned WEL_BIT      = 1;
  localparam logic [3:0]  CONT_NIBBLE  = 4'hA;
  localparam logic [7:0]  SR1_NV_RESET = 8'h00;
  localparam logic [7:0]  SR2_NV_RESET = 8'h00;

  // Serial phase lengths in bits
  localparam logic [5:0] BITS_BYTE   = 6'h08;
  localparam logic [5:0] BITS_ADDR3  = 6'h18;
  localparam logic [5:0] BITS_ADDR4  = 6'h20;
  localparam logic [5:0] BITS_DUMMY  = 6'h10;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CMD    = 3'b001,
    ST_ADDR   = 3'b010,
    ST_MODE   = 3'b011,
    ST_DUMMY  = 3'b100,
    ST_DIN    = 3'b101,
    ST_DOUT   = 3'b110,
    ST_IGNORE = 3'b111
  } link_state_t;

  typedef struct packed {
    logic       cont;
    logic       quad;
    logic       addr4;
    logic       vol_en;
    logic       wel;
    logic [7:0] sr2;
    logic [7:0] sr1;
  } mode_t;

endpackage

/* bench/flash_mode_command_control_asserts.sv */
`timescale 1ns/1ns
module flash_mode_asserts (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // Link
  input wire logic        cs_n,
  input wire logic [3:0]  io_oe
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic take_rd;
  assign take_rd = hsel && htrans[1] && hready && ce && !hwrite;
  function automatic logic at(input logic [6:0] i);
    return take_rd && (haddr == {23'h0, i, 2'b00});
  endfunction
  property p_b6a; at(7'h6A) |=> hrdata == 32'h44; endproperty
  a_b6a: assert property (p_b6a) else $error("byte 6A");
  property p_b6b; at(7'h6B) |=> hrdata == 32'hFF; endproperty
  a_b6b: assert property (p_b6b) else $error("byte 6B");
  property p_b6c; at(7'h6C) |=> hrdata == 32'h88; endproperty
  a_b6c: assert property (p_b6c) else $error("byte 6C");
  property p_b6d; at(7'h6D) |=> hrdata == 32'h50; endproperty
  a_b6d: assert property (p_b6d) else $error("byte 6D");
  property p_b6e; at(7'h6E) |=> hrdata == 32'h0; endproperty
  a_b6e: assert property (p_b6e) else $error("byte 6E");
  property p_b6f; at(7'h6F) ##1 1'b1 |-> hrdata == 32'h1; endproperty
  a_b6f: assert property (p_b6f) else $error("byte 6F");
  property p_oe_idle; cs_n |-> io_oe == 4'h0; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
  property p_oe_w; io_oe != 4'h0 |-> io_oe inside {4'h2, 4'hF}; endproperty
  a_oe_w: assert property (p_oe_w) else $error("oe width");
endmodule // flash_mode_asserts

bind flash_mode_command_control flash_mode_asserts u_chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .cs_n(cs_n), .io_oe(io_oe));

/* bench/spi_host_model.sv */
`timescale 1ns/1ns
module spi_host_model (
  // Link
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      io_i,
  input  wire logic [3:0] io_o,
  // Pace
  input  wire logic       slow
);
  logic [7:0] rx = 8'h00;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_i = 4'h5;
  end
  task automatic start();
    #5;
    cs_n = 1'b0;
  endtask
  task automatic stop();
    #5;
    cs_n = 1'b1;
    io_i = ~io_i; // Released lines must not keep a stale value
  endtask
  // Clock low between units; slow stretches the low time
  task automatic send(input logic [31:0] v, input int n, input bit q);
    for (int k = n - 1; k >= 0; k--) begin
      io_i = q ? v[4*k +: 4] : {~io_i[3:1], v[k]};
      #6;
      rx = {rx[6:0], io_o[1]};
      sclk = 1'b1;
      #7;
      sclk = 1'b0;
      #2;
      if (slow) #30;
    end
  endtask
endmodule // spi_host_model

/* bench/tb_flash_mode_command_control.sv */
`timescale 1ns/1ns
module tb_flash_mode_command_control;
  logic        hclk, hsel = 1'b0, hwrite = 1'b0, hresetn = 1'b0;
  logic        ce = 1'b1, slow = 1'b0, hreadyout, hresp;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic        sclk, cs_n;
  logic [3:0]  io_i, io_o, io_oe;
  int          fail_count = 0, total_checks = 0, cycles = 0;
  logic [7:0]  sr1 = 8'h00, sr2 = 8'h00, nv1 = 8'h00, nv2 = 8'h00;
  logic        wel = 0, vol = 0, a4 = 0, qd = 0, ct = 0, arm = 0, en = 1;
  logic [15:0] d;
  logic [7:0]  pv [6] = '{8'h44, 8'hFF, 8'h88, 8'h50, 8'h00, 8'h01};

  flash_mode_command_control DUT (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o),
    .io_oe(io_oe));
  spi_host_model host (
    .sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .slow(slow));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic status();
    repeat (8) @(posedge hclk);
    ahb(1'b0, 32'h1C0, 32'h0, r);
    chk(r, {11'h0, ct, qd, a4, vol, wel, sr2, sr1});
  endtask
  // Reference of the mode state, advanced once per frame
  task automatic model(input logic [7:0] op, input logic [15:0] v, int nb);
    if (!en) op = 8'h00;
    case (op)
      8'h06: wel = 1'b1;
      8'h50: vol = 1'b1;
      8'h01: if (wel || vol) begin
        sr1 = (nb == 2) ? v[15:8] : v[7:0];
        sr1[1] = 1'b0;
        if (nb == 2) sr2 = v[7:0];
        if (!vol) {nv1, nv2} = {sr1, sr2};
        {wel, vol} = 2'b00;
      end
      8'h99: if (arm) {sr1, sr2, qd, a4, ct, wel, vol} = {nv1, nv2, 5'h00};
      8'hB7: a4 = 1'b1;
      8'hE9: a4 = 1'b0;
      8'h38: if (sr2[1]) qd = 1'b1;
      8'hFF: qd = 1'b0;
      default: ;
    endcase
    arm = (op == 8'h66);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] v = 16'h0,
                     input int nb = 0);
    host.start();
    host.send({24'h0, op}, qd ? 2 : 8, qd);
    if (nb > 0) host.send({16'h0, v}, qd ? 2 * nb : 8 * nb, qd);
    host.stop();
    model(op, v, nb);
    status();
  endtask
  task automatic cread(input bit skip, input logic [7:0] mode);
    host.start();
    if (!skip) host.send(32'hEB, 8, 1'b0);
    host.send(32'h123456, 6, 1'b1);
    host.send({24'h0, mode}, 2, 1'b1);
    host.send(32'h0, 4, 1'b1);
    host.stop();
    ct = (mode[7:4] == 4'hA);
    arm = 1'b0;
    status();
  endtask

  initial begin
    void'($urandom(26857));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    host.start();
    host.send(32'h0, 8, 1'b0);
    host.stop();
    @(posedge hclk);
    for (int i = 0; i < 6; i++) begin
      rdchk(32'h1A8 + 4 * i, {24'h0, pv[i]});
      ahb(1'b1, 32'h1A8 + 4 * i, $urandom, r);
      rdchk(32'h1A8 + 4 * i, {24'h0, pv[i]});
    end
    rdchk(32'h1C8, 32'h0);
    rdchk(32'h1C4, 32'h1);
    status();
    d = (16'($urandom) & 16'hFDFF) | 16'h0002;
    cmd(8'h01, d, 2);
    cmd(8'h06);
    cmd(8'h01, d, 2);
    cmd(8'h06);
    cmd(8'h01, {8'h00, d[15:8] ^ 8'h81}, 1);
    cmd(8'h06);
    cmd(8'h01, d & 16'hFFFD, 2);
    cmd(8'h38);
    cmd(8'h06);
    cmd(8'h01, d, 2);
    slow = 1'b1;
    cmd(8'h50);
    cmd(8'h01, ~d & 16'hFDFF, 2);
    slow = 1'b0;
    cmd(8'h99);
    cmd(8'h66);
    cmd(8'hB7);
    cmd(8'h99);
    cmd(8'h66);
    cmd(8'h99);
    cmd(8'hB7);
    cmd(8'hE9);
    cmd(8'h38);
    cmd(8'h66);
    cmd(8'h99);
    cmd(8'h38);
    cmd(8'hFF);
    cread(1'b0, 8'hA5);
    cread(1'b1, 8'h3C);
    host.start();
    host.send(32'h05, 8, 1'b0);
    host.send(32'h0, 8, 1'b0);
    host.stop();
    chk({24'h0, host.rx}, {24'h0, sr1[7:2], wel, sr1[0]});
    ahb(1'b1, 32'h1C4, 32'h0, r);
    en = 1'b0;
    cmd(8'hB7);
    ahb(1'b1, 32'h1C4, 32'h1, r);
    en = 1'b1;
    rdchk(32'h1C4, 32'h1);
    cmd(8'hB7);
    // Bus state frozen while the enable is low
    ce <= 1'b0;
    ahb(1'b1, 32'h1C4, 32'h0, r);
    ce <= 1'b1;
    rdchk(32'h1C4, 32'h1);
    finish_test();
  end
endmodule // tb_flash_mode_command_control
